// ### hw/stack_pointer_select_update.sv
// Operation
// - register seven is the stack pointer
// - privilege flag picks active stack pointer
// - privileged uses privileged pointer, other hidden
// - unprivileged uses unprivileged pointer except for traps
// - stacks grow downward
// - predecrement pushes, postincrement pulls
// - calls push counter, returns restore it
// - traps save counter and status privileged
// - stack entries stay word aligned
// - stack bytes sit in upper half
// - predecrement updates then addresses
// - postincrement addresses then updates
// - general move allows all sizes
// - address moves refuse byte size
module stack_pointer_select_update
	import stack_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   req_valid,
	input  wire stack_pkg::ptr_req_t    req,
	input  wire logic [15:0]            status_word,
	input  wire logic                   wr_valid,
	input  wire logic [2:0]             wr_reg,
	input  wire logic [31:0]            wr_data,
	input  wire logic                   wr_alt_sp,
	output logic                        step_valid_ff,
	output stack_pkg::mem_step_t        step_ff,
	output logic                        trap_stacked_ff,
	output logic                        size_fault_ff,
	output logic [31:0]                 active_stack_pointer_ff,
	output logic                        priv_ff
);
	// ----------------------------------------------------------------
	// pointer storage
	// ----------------------------------------------------------------
	logic [31:0] general_pointer_regs [0:6]; // pointer regs zero to six
	logic [31:0] privileged_stack_pointer;   // privileged stack top
	logic [31:0] unprivileged_stack_pointer; // unprivileged stack top
	logic        priv;                       // current privilege state
	logic        trap_phase_ff;              // second trap push pending
	logic [31:0] trap_ptr_ff;                // privileged ptr mid trap
	logic        is_sp;                      // request names stack ptr
	logic [31:0] base;                       // selected register value
	logic [31:0] dec_val;                    // pointer minus step
	logic [31:0] inc_val;                    // pointer plus step
	logic [31:0] sel_sp;                     // active stack pointer
	logic        bad_size;                   // refused address move
	opsize_t     eff_size;                   // size used for step

	assign priv = status_word[priv_bit_pos];

	// active stack pointer follows privilege flag
	always_comb
	begin
		if (priv)
			sel_sp = privileged_stack_pointer;
		else
			sel_sp = unprivileged_stack_pointer;
	end

	// pick register; seven means active stack pointer
	always_comb
	begin
		is_sp = (req.reg_num == sp_reg_num);
		if (req.mode == mode_call || req.mode == mode_ret)
			is_sp = 1'b1;
		if (req.mode == mode_trap)
			base = trap_phase_ff ? trap_ptr_ff
				: privileged_stack_pointer;
		else if (is_sp)
			base = sel_sp;
		else
			base = general_pointer_regs[req.reg_num];
		// counter goes out long, the status word of a trap as a word
		if (req.mode == mode_call || req.mode == mode_ret)
			eff_size = size_long;
		else if (req.mode == mode_trap)
			eff_size = trap_phase_ff ? size_word : size_long;
		else
			eff_size = req.size;
	end

	// byte moves into address registers are refused
	always_comb
	begin
		bad_size = req.dest_an && (req.size == size_byte);
	end

	ptr_adjust ptr_adjust_i
	(
		.base    (base),
		.size    (eff_size),
		.on_sp   (is_sp || req.mode == mode_trap),
		.dec_val (dec_val),
		.inc_val (inc_val)
	);

	// ----------------------------------------------------------------
	// register updates
	// ----------------------------------------------------------------
	// general pointer registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int i = 0; i < 7; i++)
				general_pointer_regs[i] <= ptr_reset_val;
		end
		else if (wr_valid && wr_reg != sp_reg_num)
			general_pointer_regs[wr_reg] <= wr_data;
		else if (req_valid && !bad_size && !is_sp
			&& req.mode == mode_predec)
			general_pointer_regs[req.reg_num] <= dec_val;
		else if (req_valid && !bad_size && !is_sp
			&& req.mode == mode_postinc)
			general_pointer_regs[req.reg_num] <= inc_val;
	end

	// privileged stack pointer; only a trap reaches it when unprivileged
	always_ff @(posedge clock)
	begin
		if (rst)
			privileged_stack_pointer <= ptr_reset_val;
		else if (req_valid && req.mode == mode_trap && trap_phase_ff)
			privileged_stack_pointer <= dec_val;
		else if (priv && wr_valid && wr_reg == sp_reg_num && !wr_alt_sp)
			privileged_stack_pointer <= wr_data;
		else if (priv && req_valid && !bad_size && is_sp
			&& (req.mode == mode_predec || req.mode == mode_call))
			privileged_stack_pointer <= dec_val;
		else if (priv && req_valid && !bad_size && is_sp
			&& (req.mode == mode_postinc || req.mode == mode_ret))
			privileged_stack_pointer <= inc_val;
	end

	// unprivileged stack pointer; reached in privileged via alt write
	always_ff @(posedge clock)
	begin
		if (rst)
			unprivileged_stack_pointer <= ptr_reset_val;
		else if (wr_valid && wr_reg == sp_reg_num
			&& (!priv || wr_alt_sp))
			unprivileged_stack_pointer <= wr_data;
		else if (!priv && req_valid && !bad_size && is_sp
			&& req.mode != mode_trap
			&& (req.mode == mode_predec || req.mode == mode_call))
			unprivileged_stack_pointer <= dec_val;
		else if (!priv && req_valid && !bad_size && is_sp
			&& (req.mode == mode_postinc || req.mode == mode_ret))
			unprivileged_stack_pointer <= inc_val;
	end

	// trap sequencing: first push counter, then status word
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			trap_phase_ff <= 1'b0;
			trap_ptr_ff   <= ptr_reset_val;
		end
		else if (req_valid && req.mode == mode_trap && !trap_phase_ff)
		begin
			trap_phase_ff <= 1'b1;
			trap_ptr_ff   <= dec_val;
		end
		else if (req_valid && req.mode == mode_trap)
			trap_phase_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// memory step output
	// ----------------------------------------------------------------
	// address used: new value for predec, old value for postinc
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			step_valid_ff <= 1'b0;
			step_ff       <= '0;
		end
		else
		begin
			step_valid_ff  <= req_valid && !bad_size
				&& req.mode != mode_direct;
			step_ff.valid  <= req_valid && !bad_size
				&& req.mode != mode_direct;
			step_ff.size   <= (req.mode == mode_trap && trap_phase_ff)
				? size_word : eff_size;
			step_ff.write  <= req.mode == mode_predec
				|| req.mode == mode_call || req.mode == mode_trap;
			// byte on stack lands in the high half
			step_ff.upper  <= is_sp && req.size == size_byte;
			case (req.mode)
				mode_predec, mode_call, mode_trap:
					step_ff.addr <= dec_val;
				mode_postinc, mode_ret, mode_indirect:
					step_ff.addr <= base;
				default:
					step_ff.addr <= base;
			endcase
		end
	end

	// status outputs
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			size_fault_ff           <= 1'b0;
			trap_stacked_ff         <= 1'b0;
			active_stack_pointer_ff <= ptr_reset_val;
			priv_ff                 <= 1'b0;
		end
		else
		begin
			size_fault_ff   <= req_valid && bad_size;
			trap_stacked_ff <= req_valid && req.mode == mode_trap
				&& trap_phase_ff;
			active_stack_pointer_ff <= sel_sp;
			priv_ff         <= priv;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_sp_even: assert property (@(posedge clock) disable iff (rst)
		req_valid && is_sp && req.mode == mode_predec && !sel_sp[0]
		|=> !step_ff.addr[0])
		else $error("stack step address odd");
	chk_predec_addr: assert property (@(posedge clock)
		disable iff (rst)
		req_valid && !bad_size && req.mode == mode_predec
		|=> step_ff.addr == $past(base) - $past(step_bytes(eff_size,
			is_sp)))
		else $error("predecrement address wrong");
	chk_postinc_addr: assert property (@(posedge clock)
		disable iff (rst)
		req_valid && !bad_size && req.mode == mode_postinc
		|=> step_ff.addr == $past(base))
		else $error("postincrement address wrong");
	chk_byte_refuse: assert property (@(posedge clock)
		disable iff (rst)
		req_valid && bad_size |=> size_fault_ff && !step_valid_ff)
		else $error("byte address move accepted");
	chk_sp_select: assert property (@(posedge clock) disable iff (rst)
		##1 active_stack_pointer_ff == (priv_ff
			? $past(privileged_stack_pointer)
			: $past(unprivileged_stack_pointer)))
		else $error("active stack pointer wrong");
	chk_trap_priv: assert property (@(posedge clock) disable iff (rst)
		req_valid && req.mode == mode_trap
		|=> step_ff.addr == $past(dec_val) && step_ff.write)
		else $error("trap push not on privileged stack");
	chk_byte_upper: assert property (@(posedge clock)
		disable iff (rst)
		req_valid && is_sp && req.size == size_byte
		&& req.mode == mode_predec |=> step_ff.upper)
		else $error("stack byte not in upper half");
	chk_call_push: assert property (@(posedge clock) disable iff (rst)
		req_valid && req.mode == mode_call
		|=> step_ff.write && step_ff.size == size_long)
		else $error("call push wrong");
	cov_trap: cover property (@(posedge clock) trap_stacked_ff);
	cov_fault: cover property (@(posedge clock) size_fault_ff);
	cov_ret: cover property (@(posedge clock)
		req_valid && req.mode == mode_ret);
endmodule

// ### hw/stack_pkg.sv
package stack_pkg;

	// ----------------------------------------------------------------
	// sizes and constants
	// ----------------------------------------------------------------
	localparam int unsigned addr_w        = 32;    // address width
	localparam logic [2:0]  sp_reg_num    = 3'h7;  // stack register index
	localparam logic [31:0] ptr_reset_val = 32'h0; // pointer value at reset
	localparam logic [31:0] adj_byte      = 32'h1; // byte step
	localparam logic [31:0] adj_word      = 32'h2; // word step
	localparam logic [31:0] adj_long      = 32'h4; // long step
	localparam int unsigned status_w      = 16;    // status word width
	localparam int unsigned priv_bit_pos  = 13;    // privilege flag position

	// operand size
	typedef enum logic [1:0]
	{
		size_byte,
		size_word,
		size_long,
		size_bad
	} opsize_t;

	// pointer access mode
	typedef enum logic [2:0]
	{
		mode_direct,
		mode_indirect,
		mode_postinc,
		mode_predec,
		mode_call,
		mode_ret,
		mode_trap
	} ptr_mode_t;

	// one request from the sequencer
	typedef struct packed
	{
		ptr_mode_t  mode;     // access mode
		logic [2:0] reg_num;  // address register index
		opsize_t    size;     // operand size
		logic       dest_an;  // move with address register destination
	} ptr_req_t;

	// one memory step out to the bus
	typedef struct packed
	{
		logic        valid;   // step present
		logic        write;   // write when set
		logic [31:0] addr;    // byte address
		opsize_t     size;    // bus size
		logic        upper;   // byte in upper half of word
	} mem_step_t;

	// adjustment in bytes for a size; byte on stack keeps word steps
	function automatic logic [31:0] step_bytes(opsize_t s, logic on_sp);
		logic [31:0] r;
		r = adj_byte;
		case (s)
			size_byte: r = on_sp ? adj_word : adj_byte;
			size_word: r = adj_word;
			size_long: r = adj_long;
			default:   r = adj_word;
		endcase
		return r;
	endfunction

endpackage

// ### hw/ptr_adjust.sv
// pointer arithmetic for post-increment and pre-decrement
module ptr_adjust
	import stack_pkg::*;
(
	input  wire logic [31:0]          base,
	input  wire stack_pkg::opsize_t   size,
	input  wire logic                 on_sp,
	output logic      [31:0]          dec_val,
	output logic      [31:0]          inc_val
);
	logic [31:0] step; // bytes to move

	// size to step
	always_comb
	begin
		step = step_bytes(size, on_sp);
	end

	// down for push, up for pull
	always_comb
	begin
		dec_val = base - step;
		inc_val = base + step;
	end
endmodule

// ### dv/stack_mem_model.sv
// memory on the far side of the processor bus
module stack_mem_model
	import stack_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire logic                 step_valid,
	input  wire stack_pkg::mem_step_t step,
	output int                        odd_hits
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// bus watch
	// ----------------------------------------------------------------
	// counts wide steps and stack byte steps that land on an odd address
	always @(posedge clock)
	begin
		if (rst)
			odd_hits <= 0;
		else if (step_valid && (step.size != size_byte || step.upper)
			&& step.addr[0])
			odd_hits <= odd_hits + 1;
	end
endmodule

// ### dv/tb_stack_pointer_select_update.sv
module tb_stack_pointer_select_update;
	timeunit 1ns;
	timeprecision 1ns;
	import stack_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clock;                   // 25 MHz clock
	logic        rst;                     // sync reset
	logic        req_valid;               // request strobe
	ptr_req_t    req;                     // request fields
	logic [15:0] status_word;             // privilege source
	logic        wr_valid;                // register load
	logic [2:0]  wr_reg;                  // load target
	logic [31:0] wr_data;                 // load value
	logic        wr_alt_sp;               // alternate pointer load
	logic        step_valid_ff;           // step pulse
	mem_step_t   step_ff;                 // step fields
	logic        trap_stacked_ff;         // second trap push
	logic        size_fault_ff;           // refused move
	logic [31:0] active_stack_pointer_ff; // active pointer
	logic        priv_ff;                 // registered privilege
	int          odd_hits;                // misaligned steps seen
	int          failures;                // mismatches
	int          n_compared;              // comparisons
	mem_step_t   st;                      // captured step
	logic        sv;                      // captured step pulse
	logic        tf;                      // captured trap pulse
	logic        sf;                      // captured fault pulse

	stack_pointer_select_update stack_pointer_select_update_i (
		.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
		.status_word(status_word), .wr_valid(wr_valid), .wr_reg(wr_reg),
		.wr_data(wr_data), .wr_alt_sp(wr_alt_sp),
		.step_valid_ff(step_valid_ff), .step_ff(step_ff),
		.trap_stacked_ff(trap_stacked_ff), .size_fault_ff(size_fault_ff),
		.active_stack_pointer_ff(active_stack_pointer_ff),
		.priv_ff(priv_ff));

	stack_mem_model stack_mem_model_i (
		.clock(clock), .rst(rst), .step_valid(step_valid_ff),
		.step(step_ff), .odd_hits(odd_hits));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	always #20 clock = ~clock;

	task automatic check(logic [31:0] got, logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// load one address register, then a quiet cycle
	task automatic wr(logic [2:0] r, logic [31:0] d, logic alt);
		wr_valid = 1'b1;
		wr_reg = r;
		wr_data = d;
		wr_alt_sp = alt;
		@(posedge clock);
		#1;
		wr_valid = 1'b0;
		@(posedge clock);
		#1;
	endtask

	// one request; hold keeps the strobe up for a back-to-back one
	task automatic send(ptr_mode_t m, logic [2:0] r, opsize_t s, logic d,
		logic hold);
		req_valid = 1'b1;
		req = '{m, r, s, d};
		@(posedge clock);
		#1;
		st = step_ff;
		sv = step_valid_ff;
		tf = trap_stacked_ff;
		sf = size_fault_ff;
		if (!hold)
		begin
			req_valid = 1'b0;
			@(posedge clock);
			#1;
		end
	endtask

	task automatic step_is(logic w, logic [31:0] a, opsize_t s, logic up);
		check(32'(sv), 32'h1);
		check(32'(st.valid), 32'h1);
		check(32'(st.write), 32'(w));
		check(st.addr, a);
		check(32'(st.size), 32'(s));
		check(32'(st.upper), 32'(up));
	endtask

	// pointer settles after the pointer register and active pointer output stages
	task automatic sp_is(logic [31:0] e);
		repeat (2) @(posedge clock);
		#1;
		check(active_stack_pointer_ff, e);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_select();
		status_word = 16'h2000;
		wr(3'h7, 32'h200, 1'b1);
		wr(3'h7, 32'h100, 1'b0);
		sp_is(32'h100);
		check(32'(priv_ff), 32'h1);
		status_word = 16'h0000;
		sp_is(32'h200);
		check(32'(priv_ff), 32'h0);
		wr(3'h7, 32'h300, 1'b1);
		sp_is(32'h300);
		status_word = 16'h2000;
		sp_is(32'h100);
	endtask

	// back-to-back pushes and pulls through the stack pointer
	task automatic t_push();
		send(mode_predec, 3'h7, size_long, 1'b0, 1'b1);
		step_is(1'b1, 32'hfc, size_long, 1'b0);
		send(mode_predec, 3'h7, size_byte, 1'b0, 1'b1);
		step_is(1'b1, 32'hfa, size_byte, 1'b1);
		send(mode_postinc, 3'h7, size_byte, 1'b0, 1'b1);
		step_is(1'b0, 32'hfa, size_byte, 1'b1);
		send(mode_postinc, 3'h7, size_word, 1'b0, 1'b0);
		step_is(1'b0, 32'hfc, size_word, 1'b0);
		sp_is(32'hfe);
	endtask

	// user stack on a general register keeps single byte steps
	task automatic t_general();
		wr(3'h2, 32'h40, 1'b0);
		send(mode_predec, 3'h2, size_byte, 1'b0, 1'b1);
		check(st.addr, 32'h3f);
		send(mode_postinc, 3'h2, size_byte, 1'b0, 1'b1);
		check(st.addr, 32'h3f);
		send(mode_postinc, 3'h2, size_word, 1'b0, 1'b0);
		check(st.addr, 32'h40);
	endtask

	task automatic t_call();
		status_word = 16'h0000;
		send(mode_call, 3'h7, size_long, 1'b0, 1'b1);
		step_is(1'b1, 32'h2fc, size_long, 1'b0);
		send(mode_ret, 3'h7, size_long, 1'b0, 1'b0);
		step_is(1'b0, 32'h2fc, size_long, 1'b0);
		sp_is(32'h300);
	endtask

	// trap from user state lands on the privileged stack
	task automatic t_trap();
		send(mode_trap, 3'h7, size_long, 1'b0, 1'b1);
		step_is(1'b1, 32'hfa, size_long, 1'b0);
		send(mode_trap, 3'h7, size_word, 1'b0, 1'b0);
		step_is(1'b1, 32'hf8, size_word, 1'b0);
		check(32'(tf), 32'h1);
		sp_is(32'h300);
		status_word = 16'h2000;
		sp_is(32'hf8);
	endtask

	task automatic t_fault();
		send(mode_postinc, 3'h7, size_byte, 1'b1, 1'b0);
		check(32'(sf), 32'h1);
		check(32'(sv), 32'h0);
		sp_is(32'hf8);
		send(mode_direct, 3'h7, size_word, 1'b1, 1'b0);
		check(32'(sf), 32'h0);
		check(32'(sv), 32'h0);
		// plain byte read through a general register
		send(mode_indirect, 3'h2, size_byte, 1'b0, 1'b0);
		step_is(1'b0, 32'h42, size_byte, 1'b0);
		check(32'(sf), 32'h0);
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		status_word = 16'h0000;
		wr_valid = 1'b0;
		wr_reg = 3'h0;
		wr_data = 32'h0;
		wr_alt_sp = 1'b0;
		failures = 0;
		n_compared = 0;
		repeat (16) @(posedge clock);
		#1;
		rst = 1'b0;
		t_select();
		t_push();
		t_general();
		t_call();
		t_trap();
		t_fault();
		check(32'(odd_hits), 32'h0);
		stop_test();
	end

	initial
	begin
		#100000;
		failures++;
		stop_test();
	end
endmodule
